// [rtl/tsic_top.sv]
// Purpose: two-stage interrupt controller, system routing stage plus core event stage
// Assumes: core pipeline pulses evt_accept while svc_req is high, evt_return on handler exit
// Notes: all inputs synchronous to sys_clk; registers on a plain strobe port
//
// Contract
// - software rewrites per-source level routing
// - default errors to level 7, rtc/dma0 8
// - default serial port dma 9, spi/uart dma 10
// - default timers 11, flags 12, mdma/watchdog 13
// - latch, mask, pending registers, sixteen bits each
// - latch hardware updated; software writes only masked bits
// - mask bit gates servicing, latch stays set
// - core mask access only in supervisor mode
// - global enable/disable instructions gate general levels
// - pending marks active or nested; read only
// - peripheral mask, status, wakeup: 32 bits
// - peripheral mask bit passes or blocks request
// - status bit shows peripheral asserting now
// - enabled peripheral event wakes idle core
// - tolerate simultaneous pulses on shared levels
// - pending serves as acknowledgement to system stage; code: no pending path reaches the system stage
// - rising edge sets latch, two cycles
// - pending set clears latch, rearms edge
// - pending at least three cycles after edge
// - nine general levels 7..15, lower number wins

`timescale 1ns/1ps

module tsic_top (
    input wire logic sys_clk,             // core clock, 200 MHz
    input wire logic sys_rst,             // synchronous reset, active high
    input wire logic [23:0] periph_irq,   // peripheral request levels
    input wire logic [6:0] core_evt_in,   // dedicated core events 0..6
    input wire logic sup_mode,            // processor is in supervisor mode
    input wire logic core_idle,           // core is idled
    input wire logic glb_en_instr,        // global_irq_enable_instr executed, pulse
    input wire logic glb_dis_instr,       // global_irq_disable_instr executed, pulse
    input wire logic evt_accept,          // pipeline takes the offered event, pulse
    input wire logic evt_return,          // return from the highest active event, pulse
    input wire logic [7:0] reg_addr,      // register byte address
    input wire logic [31:0] reg_wdata,    // register write data
    input wire logic reg_wr,              // write strobe
    input wire logic reg_rd,              // read strobe
    output logic [31:0] reg_rdata,        // read data, cycle after reg_rd
    output logic svc_req,                 // an event outranks the active one
    output logic [3:0] svc_level,         // number of the offered event
    output logic [15:0] core_pend,        // core_event_pending
    output logic wake_req                 // wake the idle core
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] core_latch, next_core_latch;    // core_event_latch
    logic [15:0] core_mask, next_core_mask;      // core_event_mask
    logic [15:0] next_core_pend;                 // next pending
    logic [31:0] periph_mask, next_periph_mask;  // peripheral_irq_mask
    logic [31:0] periph_stat, next_periph_stat;  // peripheral_irq_status
    logic [31:0] periph_wake, next_periph_wake;  // peripheral_wakeup_enable
    logic [95:0] assign_flat, next_assign_flat;  // interrupt_assignment_regs
    logic glb_en, next_glb_en;                   // general levels globally enabled
    logic [15:0] in_q, in_qq;                    // edge detector stages
    logic [15:0] next_in_q;                      // sampled event inputs
    logic [15:0] edge_vec;                       // rising edges seen this cycle
    logic [8:0] gen_req;                         // routed general-level requests
    logic [31:0] next_reg_rdata;                 // next read data
    logic next_svc_req;                          // next offer
    logic [3:0] next_svc_level;                  // next offered number
    logic next_wake_req;                         // next wake
    logic [4:0] cand_idx;                        // best ready event
    logic [4:0] act_idx;                         // highest active event
    logic [15:0] ready_vec;                      // latched, unmasked, enabled

    // lowest set bit, NUM_EVT when none; lower number is higher priority
    function automatic logic [4:0] low_idx(input logic [15:0] v);
        logic [4:0] r;
        r = 5'(tsic_pkg::NUM_EVT);
        for (int i = tsic_pkg::NUM_EVT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : low_idx

    // keep a routing code inside 0..8, levels 7..15; out-of-range codes fold to level 15
    function automatic logic [31:0] clamp_codes(input logic [31:0] w);
        logic [31:0] r;
        r = w;
        for (int n = 0; n < tsic_pkg::SRC_PER_REG; n++) begin
            if (w[n*tsic_pkg::CODE_W +: tsic_pkg::CODE_W] > tsic_pkg::CODE_MAX) begin
                r[n*tsic_pkg::CODE_W +: tsic_pkg::CODE_W] = tsic_pkg::CODE_MAX;
            end
        end
        return r;
    endfunction : clamp_codes

    // ----------------------------------------------------------------
    // system stage
    // ----------------------------------------------------------------
    tsic_sys_route u_route (
        .periph_irq(periph_irq),
        .periph_mask(periph_mask),
        .assign_flat(assign_flat),
        .gen_req(gen_req)
    );

    // ----------------------------------------------------------------
    // register writes and system-stage state
    // ----------------------------------------------------------------
    // core registers are refused outside supervisor mode
    always_comb begin
        next_periph_mask = periph_mask;
        next_periph_wake = periph_wake;
        next_assign_flat = assign_flat;
        next_core_mask = core_mask;
        next_periph_stat = {8'h00, periph_irq} & tsic_pkg::SRC_BITS;
        next_glb_en = glb_en;
        if (glb_en_instr) begin
            next_glb_en = 1'b1;
        end
        if (glb_dis_instr) begin
            next_glb_en = 1'b0;
        end
        if (reg_wr) begin
            case (reg_addr)
                tsic_pkg::ADDR_CORE_MASK: begin
                    if (sup_mode) begin
                        next_core_mask = reg_wdata[15:0];
                    end
                end
                tsic_pkg::ADDR_PERIPH_MASK: next_periph_mask = reg_wdata & tsic_pkg::SRC_BITS;
                tsic_pkg::ADDR_PERIPH_WAKE: next_periph_wake = reg_wdata & tsic_pkg::SRC_BITS;
                tsic_pkg::ADDR_ASSIGN0: next_assign_flat[31:0] = clamp_codes(reg_wdata);
                tsic_pkg::ADDR_ASSIGN1: next_assign_flat[63:32] = clamp_codes(reg_wdata);
                tsic_pkg::ADDR_ASSIGN2: next_assign_flat[95:64] = clamp_codes(reg_wdata);
                default: begin
                    // read-only or unmapped: write ignored; core latch writes are taken in the core stage
                end
            endcase
        end
        // wake only from an enabled source asserting while the core idles
        next_wake_req = core_idle && ((periph_irq & periph_wake[23:0]) != 24'h000000);
    end

    // system-stage registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            periph_mask <= tsic_pkg::RST_PERIPH_MASK;
            periph_wake <= tsic_pkg::RST_PERIPH_WAKE;
            periph_stat <= 32'h0000_0000;
            assign_flat <= {tsic_pkg::RST_ASSIGN2, tsic_pkg::RST_ASSIGN1, tsic_pkg::RST_ASSIGN0};
            core_mask <= tsic_pkg::RST_CORE_MASK;
            glb_en <= tsic_pkg::RST_GLB_EN;
            wake_req <= 1'b0;
        end else begin
            periph_mask <= next_periph_mask;
            periph_wake <= next_periph_wake;
            periph_stat <= next_periph_stat;
            assign_flat <= next_assign_flat;
            core_mask <= next_core_mask;
            glb_en <= next_glb_en;
            wake_req <= next_wake_req;
        end
    end

    // ----------------------------------------------------------------
    // core stage: edges, latch, pending, offer
    // ----------------------------------------------------------------
    // edge detection spans two clocks: sample, then compare with the prior sample
    always_comb begin
        next_in_q = {gen_req, core_evt_in};
        edge_vec = in_q & ~in_qq;
        ready_vec = core_latch & core_mask & (glb_en ? 16'hffff : ~tsic_pkg::GEN_LEVEL_BITS);
        cand_idx = low_idx(ready_vec);
        act_idx = low_idx(core_pend);
        next_core_latch = core_latch;
        next_core_pend = core_pend;
        // accepting moves the offered event from latch into pending
        if (svc_req && evt_accept) begin
            next_core_pend[svc_level] = 1'b1;
            next_core_latch[svc_level] = 1'b0;
        end
        // a handler exit retires the highest active event only
        if (evt_return && (act_idx < 5'(tsic_pkg::NUM_EVT))) begin
            next_core_pend[act_idx[3:0]] = 1'b0;
        end
        // software may only touch latch bits whose mask bit is clear
        if (reg_wr && sup_mode && (reg_addr == tsic_pkg::ADDR_CORE_LATCH)) begin
            next_core_latch = (next_core_latch & core_mask) | (reg_wdata[15:0] & ~core_mask);
        end
        // a new edge wins over any clear in the same cycle
        next_core_latch = next_core_latch | edge_vec;
        // offer only what outranks the active event; pause one cycle after an accept
        next_svc_req = (cand_idx < act_idx) && !(svc_req && evt_accept);
        next_svc_level = cand_idx[3:0];
    end

    // core-stage registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_q <= 16'h0000;
            in_qq <= 16'h0000;
            core_latch <= 16'h0000;
            core_pend <= 16'h0000;
            svc_req <= 1'b0;
            svc_level <= 4'h0;
        end else begin
            in_q <= next_in_q;
            in_qq <= in_q;
            core_latch <= next_core_latch;
            core_pend <= next_core_pend;
            svc_req <= next_svc_req;
            svc_level <= next_svc_level;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // data stand only in the cycle after the strobe; unmapped reads return zero
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                tsic_pkg::ADDR_CORE_LATCH: next_reg_rdata = sup_mode ? {16'h0000, core_latch} : 32'h0000_0000;
                tsic_pkg::ADDR_CORE_MASK: next_reg_rdata = sup_mode ? {16'h0000, core_mask} : 32'h0000_0000;
                tsic_pkg::ADDR_CORE_PEND: next_reg_rdata = sup_mode ? {16'h0000, core_pend} : 32'h0000_0000;
                tsic_pkg::ADDR_PERIPH_MASK: next_reg_rdata = periph_mask;
                tsic_pkg::ADDR_PERIPH_STAT: next_reg_rdata = periph_stat;
                tsic_pkg::ADDR_PERIPH_WAKE: next_reg_rdata = periph_wake;
                tsic_pkg::ADDR_ASSIGN0: next_reg_rdata = assign_flat[31:0];
                tsic_pkg::ADDR_ASSIGN1: next_reg_rdata = assign_flat[63:32];
                tsic_pkg::ADDR_ASSIGN2: next_reg_rdata = assign_flat[95:64];
                tsic_pkg::ADDR_GLB_STAT: next_reg_rdata = {31'h0000_0000, glb_en};
                default: next_reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_rise7;
        !next_in_q[7] ##1 next_in_q[7] && !core_pend[7];
    endsequence

    sequence s_taken;
        svc_req && evt_accept;
    endsequence

    AST_EDGE_LATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (edge_vec != 16'h0000) |=> ((core_latch & $past(edge_vec)) == $past(edge_vec)))
        else $error("rising edge did not set latch");

    AST_TAKE_PEND: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_taken |=> core_pend[$past(svc_level)])
        else $error("accepted event not pending");

    AST_TAKE_LATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_taken and (edge_vec == 16'h0000) and !reg_wr |=> !core_latch[$past(svc_level)])
        else $error("latch not cleared on accept");

    AST_MASK_GATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        svc_req |-> (($past(core_mask) >> svc_level) & 16'h0001) != 16'h0000)
        else $error("masked event offered");

    AST_GLOBAL_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        svc_req && (svc_level >= 4'(tsic_pkg::GEN_BASE)) |-> $past(glb_en))
        else $error("general level offered while globally disabled");

    AST_MIN_LAT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_rise7 |=> !core_pend[7] [*3])
        else $error("pending too soon after edge");

    AST_PEND_RO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_wr && !evt_accept && !evt_return |=> $stable(core_pend))
        else $error("pending changed without pipeline");

    AST_STATUS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> periph_stat[23:0] == $past(periph_irq))
        else $error("status does not follow peripherals");

    AST_PRIO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        svc_req |-> (5'(svc_level) < $past(act_idx)))
        else $error("offer does not outrank active event");

    AST_WAKE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        core_idle && ((periph_irq & periph_wake[23:0]) != 24'h000000) |=> wake_req)
        else $error("enabled wakeup missed");

    AST_SUP_MASK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_wr && !sup_mode |=> $stable(core_mask))
        else $error("mask written outside supervisor");

endmodule : tsic_top

// [rtl/tsic_pkg.sv]
// Purpose: shared constants for the two-stage interrupt controller
// Assumes: one core clock, synchronous active-high reset
// Notes: register map and default routing live here only

package tsic_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC = 24;        // peripheral interrupt sources
    localparam int NUM_EVT = 16;        // core events, one bit each
    localparam int NUM_DED = 7;         // dedicated events 0..6
    localparam int NUM_GEN = 9;         // general levels 7..15
    localparam int GEN_BASE = 7;        // number of the first general level
    localparam int CODE_W = 4;          // routing code width per source
    localparam int NUM_ASSIGN = 3;      // assignment registers
    localparam int SRC_PER_REG = 8;     // routing codes per assignment register
    localparam int DATA_W = 32;         // register bus data width
    localparam int ADDR_W = 8;          // register bus byte address width
    localparam int IDX_W = 5;           // index width, value NUM_EVT means none

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CORE_LATCH = 8'h00;    // core_event_latch
    localparam logic [7:0] ADDR_CORE_MASK = 8'h04;     // core_event_mask
    localparam logic [7:0] ADDR_CORE_PEND = 8'h08;     // core_event_pending
    localparam logic [7:0] ADDR_PERIPH_MASK = 8'h0c;   // peripheral_irq_mask
    localparam logic [7:0] ADDR_PERIPH_STAT = 8'h10;   // peripheral_irq_status
    localparam logic [7:0] ADDR_PERIPH_WAKE = 8'h14;   // peripheral_wakeup_enable
    localparam logic [7:0] ADDR_ASSIGN0 = 8'h18;       // interrupt_assignment_regs, sources 0..7
    localparam logic [7:0] ADDR_ASSIGN1 = 8'h1c;       // sources 8..15
    localparam logic [7:0] ADDR_ASSIGN2 = 8'h20;       // sources 16..23
    localparam logic [7:0] ADDR_GLB_STAT = 8'h24;      // global enable state, read only

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    // code = level minus seven, source 0 in the low nibble
    localparam logic [31:0] RST_ASSIGN0 = 32'h1000_0000;
    localparam logic [31:0] RST_ASSIGN1 = 32'h3332_2221;
    localparam logic [31:0] RST_ASSIGN2 = 32'h6665_5444;
    localparam logic [3:0] CODE_MAX = 4'h8;            // level 15
    localparam logic [15:0] RST_CORE_MASK = 16'h0000;
    localparam logic [31:0] RST_PERIPH_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_PERIPH_WAKE = 32'h0000_0000;
    localparam logic RST_GLB_EN = 1'b1;
    localparam logic [15:0] GEN_LEVEL_BITS = 16'hff80; // bits of the general levels
    localparam logic [31:0] SRC_BITS = 32'h00ff_ffff;  // implemented source bits

endpackage : tsic_pkg

// [rtl/tsic_sys_route.sv]
// Purpose: system stage routing of unmasked peripheral requests onto general levels
// Assumes: requests are levels synchronous to sys_clk
// Notes: purely combinational; the core stage registers the result

`timescale 1ns/1ps

module tsic_sys_route (
    input wire logic [23:0] periph_irq,   // raw peripheral requests
    input wire logic [31:0] periph_mask,  // peripheral_irq_mask
    input wire logic [95:0] assign_flat,  // routing codes, four bits per source
    output logic [8:0] gen_req            // one request per general level
);

    // ----------------------------------------------------------------
    // per-level or of sources
    // ----------------------------------------------------------------
    genvar lvl;
    generate
        for (lvl = 0; lvl < tsic_pkg::NUM_GEN; lvl++) begin : g_lvl
            // shared levels simply or their sources, so simultaneous pulses merge
            always_comb begin
                gen_req[lvl] = 1'b0;
                for (int s = 0; s < tsic_pkg::NUM_SRC; s++) begin
                    if (periph_irq[s] && periph_mask[s] &&
                        (assign_flat[s*tsic_pkg::CODE_W +: tsic_pkg::CODE_W] == 4'(lvl))) begin
                        gen_req[lvl] = 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule : tsic_sys_route

// [verif/tsic_core_model.sv]
// Purpose: behavioural core pipeline that takes events offered by the controller
// Assumes: svc_req is a registered level, evt_accept a one-cycle pulse
// Notes: acc_dly makes the pipeline stall before it takes an offer
`timescale 1ns/1ps

module tsic_core_model (
    input wire logic sys_clk,       // core clock
    input wire logic sys_rst,       // synchronous reset
    input wire logic svc_req,       // event offered
    input wire logic [3:0] acc_dly, // cycles to stall first
    output logic evt_accept         // take pulse
);
    logic [3:0] wait_cnt; // cycles the offer has stood

    // ----------------------------------------------------------------
    // take logic
    // ----------------------------------------------------------------
    // idle for a cycle after a take: the offer drops one cycle late,
    // so a stale level must not be taken twice
    always_ff @(posedge sys_clk) begin
        if (sys_rst || evt_accept || !svc_req) begin
            evt_accept <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= acc_dly) begin
            evt_accept <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : tsic_core_model

// [verif/tsic_top_tb_top.sv]
// Purpose: self-checking bench for the two-stage interrupt controller
// Assumes: partner model takes offered events; bench drives all else
// Notes: dedicated core events stay low, only general levels are used
`timescale 1ns/1ps

module tsic_top_tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [23:0] periph_irq = '0;
    logic sup_mode = 1'b1;
    logic core_idle = 1'b0;
    logic glb_en_instr = 1'b0, glb_dis_instr = 1'b0;
    logic evt_return = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] acc_dly = 4'h0; // partner stall
    logic evt_accept;
    logic [31:0] reg_rdata;
    logic svc_req;
    logic [3:0] svc_level;
    logic [15:0] core_pend;
    logic wake_req;
    logic [31:0] rv; // last value read
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0; // cycles run, bounds a hang

    tsic_top u_tsic_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .periph_irq(periph_irq),
        .core_evt_in(7'h00), .sup_mode(sup_mode), .core_idle(core_idle),
        .glb_en_instr(glb_en_instr), .glb_dis_instr(glb_dis_instr), .evt_accept(evt_accept),
        .evt_return(evt_return), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .svc_req(svc_req), .svc_level(svc_level),
        .core_pend(core_pend), .wake_req(wake_req));
    tsic_core_model u_tsic_core_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .svc_req(svc_req), .acc_dly(acc_dly), .evt_accept(evt_accept));

    // ----------------------------------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        chk(nm, e, rv);
    endtask : rchk
    task automatic wait_pend(output int n);
        n = 0;
        while (n < 40 && core_pend === 16'h0) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : wait_pend
    // drop the sources and leave the active handler
    task automatic release_evt();
        @(posedge sys_clk);
        periph_irq <= '0;
        evt_return <= 1'b1;
        @(posedge sys_clk);
        evt_return <= 1'b0;
        tick(2);
    endtask : release_evt

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults();
        int lvl [24] = '{7, 7, 7, 7, 7, 7, 7, 8, 8, 9, 9, 9, 9, 10, 10, 10, 11, 11, 11, 12, 12, 13, 13, 13};
        logic [31:0] e;
        for (int r = 0; r < 3; r++) begin
            e = '0;
            for (int j = 0; j < 8; j++) e[j*4 +: 4] = 4'(lvl[r*8+j] - 7);
            rchk(tsic_pkg::ADDR_ASSIGN0 + 8'(r * 4), e, "routing");
        end
        rchk(tsic_pkg::ADDR_PERIPH_MASK, 32'h0, "periph_mask");
        rchk(tsic_pkg::ADDR_GLB_STAT, 32'h1, "glb_en");
    endtask : t_defaults
    task automatic t_access();
        sup_mode <= 1'b0;
        wr(tsic_pkg::ADDR_CORE_MASK, 32'h0000_ffff);
        sup_mode <= 1'b1;
        rchk(tsic_pkg::ADDR_CORE_MASK, 32'h0, "mask_user");
        wr(tsic_pkg::ADDR_CORE_MASK, 32'hffff_a5a5);
        rchk(tsic_pkg::ADDR_CORE_MASK, 32'h0000_a5a5, "mask_rw");
        wr(tsic_pkg::ADDR_CORE_PEND, 32'hffff);
        rchk(tsic_pkg::ADDR_CORE_PEND, 32'h0, "pend_ro");
        wr(tsic_pkg::ADDR_PERIPH_WAKE, 32'hffff_ffff);
        rchk(tsic_pkg::ADDR_PERIPH_WAKE, 32'h00ff_ffff, "wake_rw");
        wr(tsic_pkg::ADDR_PERIPH_WAKE, 32'h0);
        rchk(8'h3c, 32'h0, "unmapped");
    endtask : t_access
    task automatic t_event(input logic [23:0] src, input int lvl);
        int n;
        wr(tsic_pkg::ADDR_PERIPH_MASK, 32'hffff_ffff);
        wr(tsic_pkg::ADDR_CORE_MASK, 32'h1 << lvl);
        @(posedge sys_clk) periph_irq <= src;
        wait_pend(n);
        chk("pend_delay", 32'h1, {31'h0, n >= 3 && n < 40});
        chk("pending", 32'h1 << lvl, {16'h0, core_pend});
        rchk(tsic_pkg::ADDR_CORE_LATCH, 32'h0, "latch_clr");
        rchk(tsic_pkg::ADDR_PERIPH_STAT, {8'h0, src}, "status");
        release_evt();
        chk("pend_clear", 32'h0, {16'h0, core_pend});
    endtask : t_event
    task automatic t_masks();
        wr(tsic_pkg::ADDR_CORE_MASK, 32'h0);
        @(posedge sys_clk) periph_irq <= 24'h01_0000;
        tick(6);
        chk("svc_masked", 32'h0, {31'h0, svc_req});
        rchk(tsic_pkg::ADDR_CORE_LATCH, 32'h0800, "latch_held");
        wr(tsic_pkg::ADDR_CORE_LATCH, 32'h0);
        rchk(tsic_pkg::ADDR_CORE_LATCH, 32'h0, "latch_sw");
        @(posedge sys_clk) periph_irq <= '0;
        wr(tsic_pkg::ADDR_PERIPH_MASK, 32'hfffe_ffff);
        wr(tsic_pkg::ADDR_CORE_MASK, 32'h0800);
        @(posedge sys_clk) periph_irq <= 24'h01_0000;
        tick(6);
        chk("svc_blocked", 32'h0, {31'h0, svc_req});
        rchk(tsic_pkg::ADDR_CORE_LATCH, 32'h0, "latch_blocked");
        rchk(tsic_pkg::ADDR_PERIPH_STAT, 32'h01_0000, "status_raw");
        @(posedge sys_clk) periph_irq <= '0;
    endtask : t_masks
    task automatic t_global();
        int n;
        wr(tsic_pkg::ADDR_PERIPH_MASK, 32'hffff_ffff);
        @(posedge sys_clk) glb_dis_instr <= 1'b1;
        @(posedge sys_clk) glb_dis_instr <= 1'b0;
        periph_irq <= 24'h01_0000;
        tick(6);
        chk("svc_glb_off", 32'h0, {31'h0, svc_req});
        rchk(tsic_pkg::ADDR_GLB_STAT, 32'h0, "glb_off");
        @(posedge sys_clk) glb_en_instr <= 1'b1;
        @(posedge sys_clk) glb_en_instr <= 1'b0;
        wait_pend(n);
        chk("pend_glb_on", 32'h0800, {16'h0, core_pend});
        release_evt();
    endtask : t_global
    task automatic t_prio();
        int n;
        wr(tsic_pkg::ADDR_CORE_MASK, 32'h0880);
        @(posedge sys_clk) periph_irq <= 24'h01_0001;
        wait_pend(n);
        tick(6);
        chk("prio_first", 32'h0080, {16'h0, core_pend});
        chk("prio_wait", 32'h0000_000b, {28'h0, svc_level});
        release_evt();
        wait_pend(n);
        chk("prio_next", 32'h0800, {16'h0, core_pend});
        release_evt();
    endtask : t_prio
    task automatic t_reroute();
        wr(tsic_pkg::ADDR_ASSIGN0, 32'hffff_ffff);
        rchk(tsic_pkg::ADDR_ASSIGN0, 32'h8888_8888, "route_clamp");
        wr(tsic_pkg::ADDR_ASSIGN0, tsic_pkg::RST_ASSIGN0);
        wr(tsic_pkg::ADDR_ASSIGN2, tsic_pkg::RST_ASSIGN2 & 32'hffff_fff0);
        t_event(24'h01_0000, 7);
    endtask : t_reroute
    task automatic t_wake();
        core_idle <= 1'b1;
        wr(tsic_pkg::ADDR_PERIPH_WAKE, 32'h100);
        @(posedge sys_clk) periph_irq <= 24'h00_0100;
        tick(2);
        chk("wake_on", 32'h1, {31'h0, wake_req});
        @(posedge sys_clk) periph_irq <= 24'h00_0200;
        tick(2);
        chk("wake_off", 32'h0, {31'h0, wake_req});
    endtask : t_wake

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_access();
        t_event(24'h01_0000, 11);
        acc_dly <= 4'h5;
        t_event(24'h03_0000, 11);
        acc_dly <= 4'h0;
        t_masks();
        t_global();
        t_prio();
        t_reroute();
        t_wake();
        report_and_stop();
    end
endmodule : tsic_top_tb_top
